/* File: core/boost_cfg.svh */
// Register offsets, field positions, reset values and counts for the boost control block.
`ifndef BOOST_CFG_SVH
`define BOOST_CFG_SVH

// ==========================================================================
// Register addresses
// ==========================================================================
`define ADDR_REF_COUNTER 12'h0e7
`define ADDR_ACT_COUNTER 12'h0e8
`define ADDR_PERF_STATE_READBACK 12'h198
`define ADDR_PERF_TARGET_CONTROL 12'h199
`define ADDR_MISC_FEATURE_ENABLES 12'h1a0

// ==========================================================================
// Field positions and constants
// ==========================================================================
`define BOOST_DISABLE_BIT 38
`define DISENGAGE_BIT 32
`define CAP_BOOST_BIT 1
`define CAP_LEAF_THERMAL 32'h0000_0006
`define NUM_LP 2
`define LP_IDX_W 1
`define ZERO64 64'h0000_0000_0000_0000
`define ONE64 64'h0000_0000_0000_0001
`define ALL_ONES64 64'hffff_ffff_ffff_ffff
`define RATIO_W 8
`define RATIO_ONE 8'h10

`endif

/* File: core/boost_pkg.sv */
// Types shared by the boost control block.
package boost_pkg;

	// ==========================================================================
	// Register access request
	// ==========================================================================
	typedef struct packed {
		logic rd;
		logic wr;
		logic [0:0] lp;
		logic [11:0] addr;
		logic [63:0] wdata;
	} reg_req_t;

	// Per logical processor execution and performance inputs.
	typedef struct packed {
		logic active;
		logic [7:0] ratio;
	} lp_state_t;

	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_BOOSTED
	} boost_state_t;

endpackage

/* File: core/opportunistic_boost_control.sv */
// Boost enable, disengage control and actual/reference performance counters.
`timescale 1ns/1ps
`include "boost_cfg.svh"

module opportunistic_boost_control (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_boost_hw_present,
	input wire boost_pkg::reg_req_t i_req,
	input wire logic [31:0] i_cap_leaf,
	input wire boost_pkg::lp_state_t [`NUM_LP-1:0] i_lp,
	input wire logic i_thermal_headroom,
	input wire logic i_boost_criteria_met,
	input wire logic [15:0] i_cur_operating_point,
	output logic [63:0] o_rdata,
	output logic o_rvalid,
	output logic [31:0] o_cap_eax,
	output logic [`NUM_LP-1:0] o_boost_permitted,
	output logic [`NUM_LP-1:0] o_boosted
);

	// ==========================================================================
	// State
	// ==========================================================================
	logic strap_loaded;
	logic next_strap_loaded;
	logic boost_disable;
	logic next_boost_disable;
	logic [63:0] misc_feature_enables;
	logic [63:0] next_misc_feature_enables;
	logic [63:0] perf_target_control [`NUM_LP];
	logic [63:0] next_perf_target_control [`NUM_LP];
	logic [63:0] reference_perf_counter [`NUM_LP];
	logic [63:0] next_reference_perf_counter [`NUM_LP];
	logic [63:0] actual_perf_counter [`NUM_LP];
	logic [63:0] next_actual_perf_counter [`NUM_LP];
	boost_pkg::boost_state_t bstate [`NUM_LP];
	boost_pkg::boost_state_t next_bstate [`NUM_LP];
	logic [63:0] next_rdata;
	logic next_rvalid;

	// Adds an increment to a counter and flags a wrap out of the top bit.
	function automatic logic [64:0] count_add(input logic [63:0] v, input logic [63:0] inc);
		count_add = {1'b0, v} + {1'b0, inc};
	endfunction

	// Permitted only when the package bit and this processor's disengage bit are clear.
	function automatic logic permit(input logic dis, input logic [63:0] ctl);
		permit = !dis && !ctl[`DISENGAGE_BIT];
	endfunction

	// ==========================================================================
	// Package enable bit and control registers
	// ==========================================================================
	// The strap cannot load under async reset, so it is caught on the first clocked edge.
	always_comb begin
		next_strap_loaded = 1'b1;
		next_boost_disable = boost_disable;
		next_misc_feature_enables = misc_feature_enables;
		next_perf_target_control = perf_target_control;
		if (!strap_loaded) begin
			next_boost_disable = i_boost_hw_present;
		end else if (i_req.wr && i_req.addr == `ADDR_MISC_FEATURE_ENABLES) begin
			// Any processor writes the single package copy.
			next_boost_disable = i_req.wdata[`BOOST_DISABLE_BIT];
			next_misc_feature_enables = i_req.wdata;
		end
		if (i_req.wr && i_req.addr == `ADDR_PERF_TARGET_CONTROL) begin
			next_perf_target_control[i_req.lp] = i_req.wdata;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			strap_loaded <= 1'b0;
			boost_disable <= 1'b0;
			misc_feature_enables <= `ZERO64;
			for (int i = 0; i < `NUM_LP; i++) begin
				perf_target_control[i] <= `ZERO64;
			end
		end else begin
			strap_loaded <= next_strap_loaded;
			boost_disable <= next_boost_disable;
			misc_feature_enables <= next_misc_feature_enables;
			perf_target_control <= next_perf_target_control;
		end
	end

	// ==========================================================================
	// Boost state and counters
	// ==========================================================================
	// Boost is never guaranteed: headroom and internal criteria gate it each cycle.
	always_comb begin
		logic [64:0] r_sum;
		logic [64:0] a_sum;
		logic [63:0] a_inc;
		r_sum = '0;
		a_sum = '0;
		a_inc = `ZERO64;
		for (int i = 0; i < `NUM_LP; i++) begin
			next_bstate[i] = boost_pkg::ST_NORMAL;
			if (permit(boost_disable, perf_target_control[i]) && i_thermal_headroom
				&& i_boost_criteria_met && i_lp[i].active) begin
				next_bstate[i] = boost_pkg::ST_BOOSTED;
			end
			next_reference_perf_counter[i] = reference_perf_counter[i];
			next_actual_perf_counter[i] = actual_perf_counter[i];
			if (i_lp[i].active) begin
				// Ratio is in sixteenths of the reference rate; boosted adds one step.
				case (bstate[i])
					boost_pkg::ST_BOOSTED: a_inc = {56'h0, i_lp[i].ratio} + `ONE64;
					boost_pkg::ST_NORMAL: a_inc = {56'h0, i_lp[i].ratio};
					default: a_inc = {56'h0, i_lp[i].ratio};
				endcase
				r_sum = count_add(reference_perf_counter[i], {56'h0, `RATIO_ONE});
				a_sum = count_add(actual_perf_counter[i], a_inc);
				next_reference_perf_counter[i] = r_sum[63:0];
				next_actual_perf_counter[i] = a_sum[63:0];
				if (r_sum[64] || a_sum[64]) begin
					next_reference_perf_counter[i] = `ZERO64;
					next_actual_perf_counter[i] = `ZERO64;
				end
			end
			// A software write lands on the addressed counter of the addressed processor.
			if (i_req.wr && i_req.lp == i[`LP_IDX_W-1:0]) begin
				if (i_req.addr == `ADDR_REF_COUNTER) begin
					next_reference_perf_counter[i] = i_req.wdata;
				end
				if (i_req.addr == `ADDR_ACT_COUNTER) begin
					next_actual_perf_counter[i] = i_req.wdata;
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < `NUM_LP; i++) begin
				bstate[i] <= boost_pkg::ST_NORMAL;
				reference_perf_counter[i] <= `ZERO64;
				actual_perf_counter[i] <= `ZERO64;
			end
		end else begin
			bstate <= next_bstate;
			reference_perf_counter <= next_reference_perf_counter;
			actual_perf_counter <= next_actual_perf_counter;
		end
	end

	// ==========================================================================
	// Read path and capability answer
	// ==========================================================================
	// Status bit 32 is tied low so the disengage bit never shows through.
	always_comb begin
		next_rvalid = i_req.rd;
		next_rdata = `ZERO64;
		case (i_req.addr)
			`ADDR_REF_COUNTER: next_rdata = reference_perf_counter[i_req.lp];
			`ADDR_ACT_COUNTER: next_rdata = actual_perf_counter[i_req.lp];
			`ADDR_PERF_TARGET_CONTROL: next_rdata = perf_target_control[i_req.lp];
			`ADDR_PERF_STATE_READBACK: next_rdata = {48'h0, i_cur_operating_point};
			`ADDR_MISC_FEATURE_ENABLES: begin
				next_rdata = misc_feature_enables;
				next_rdata[`BOOST_DISABLE_BIT] = boost_disable;
			end
			default: next_rdata = `ZERO64;
		endcase
		if (!i_req.rd) begin
			next_rdata = `ZERO64;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= `ZERO64;
			o_rvalid <= 1'b0;
		end else begin
			o_rdata <= next_rdata;
			o_rvalid <= next_rvalid;
		end
	end

	// Capability word is combinational from the live package bit.
	always_comb begin
		o_cap_eax = 32'h0000_0000;
		if (i_cap_leaf == `CAP_LEAF_THERMAL) begin
			o_cap_eax[`CAP_BOOST_BIT] = !boost_disable;
		end
		for (int i = 0; i < `NUM_LP; i++) begin
			o_boost_permitted[i] = permit(boost_disable, perf_target_control[i]);
			o_boosted[i] = bstate[i] == boost_pkg::ST_BOOSTED;
		end
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	property p_cap_off;
		@(posedge i_clk_sys) disable iff (i_rst)
		boost_disable |-> !o_cap_eax[`CAP_BOOST_BIT];
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("capability set while disabled");

	property p_strap;
		@(posedge i_clk_sys) disable iff (i_rst)
		!strap_loaded |=> boost_disable == $past(i_boost_hw_present);
	endproperty
	a_strap: assert property (p_strap) else $error("disable bit missed strap");

	property p_disengage;
		@(posedge i_clk_sys) disable iff (i_rst)
		perf_target_control[0][`DISENGAGE_BIT] |=> !o_boosted[0];
	endproperty
	a_disengage: assert property (p_disengage) else $error("boost while disengaged");

	property p_pkg_disable;
		@(posedge i_clk_sys) disable iff (i_rst)
		boost_disable |=> o_boosted == '0;
	endproperty
	a_pkg_disable: assert property (p_pkg_disable) else $error("boost while disabled");

	property p_no_mirror;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_req.rd && i_req.addr == `ADDR_PERF_STATE_READBACK |=> !o_rdata[`DISENGAGE_BIT];
	endproperty
	a_no_mirror: assert property (p_no_mirror) else $error("status bit 32 set");

	property p_lp_isolated;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_req.wr && i_req.addr == `ADDR_PERF_TARGET_CONTROL && i_req.lp == 1'b0
			|=> $stable(perf_target_control[1]);
	endproperty
	a_lp_isolated: assert property (p_lp_isolated) else $error("other processor changed");

	property p_idle_hold;
		@(posedge i_clk_sys) disable iff (i_rst)
		!i_lp[0].active && !i_req.wr |=> $stable(reference_perf_counter[0]);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("counter ran while idle");

	property p_wrap_both;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_lp[0].active && !i_req.wr && reference_perf_counter[0] == `ALL_ONES64
			|=> reference_perf_counter[0] == `ZERO64 && actual_perf_counter[0] == `ZERO64;
	endproperty
	a_wrap_both: assert property (p_wrap_both) else $error("overflow did not clear pair");

	property p_ratio;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_boosted[1] && i_lp[1].active && !i_req.wr && i_lp[1].ratio == `RATIO_ONE
			&& actual_perf_counter[1] < `ALL_ONES64 - 64'h20
			&& reference_perf_counter[1] < `ALL_ONES64 - 64'h20
			|=> actual_perf_counter[1] - $past(actual_perf_counter[1])
				> reference_perf_counter[1] - $past(reference_perf_counter[1]);
	endproperty
	a_ratio: assert property (p_ratio) else $error("boost not visible in ratio");

endmodule

/* File: testbench/opportunistic_boost_control_tb.sv */
// Self-checking testbench for the boost control block.
`timescale 1ns/1ps
`include "boost_cfg.svh"

module opportunistic_boost_control_tb;
	// ==========================================================================
	// Stimulus and model state
	// ==========================================================================
	logic i_clk_sys, i_rst, hw, head, crit;
	boost_pkg::reg_req_t req;
	boost_pkg::lp_state_t [1:0] lp;
	logic [31:0] leaf, rnd;
	logic [15:0] op;
	logic [63:0] rdata, q, d, bit32, bit38;
	logic rvalid;
	logic [31:0] eax;
	logic [1:0] perm, boosted;
	logic [7:0] r0;
	int miscompares, check_count;
	localparam int N = 20;

	opportunistic_boost_control uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_boost_hw_present(hw), .i_req(req), .i_cap_leaf(leaf), .i_lp(lp),
		.i_thermal_headroom(head), .i_boost_criteria_met(crit),
		.i_cur_operating_point(op), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_cap_eax(eax), .o_boost_permitted(perm), .o_boosted(boosted));

	// A 100 ns period gives the 10 MHz system clock.
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	// ==========================================================================
	// Behavioural model
	// ==========================================================================
	// Counter pairs and boost state kept from the rules with plain integers. The bench
	// drives by non-blocking assignment, so this process sees what the design samples.
	longint unsigned m_ref [2];
	longint unsigned m_act [2];
	longint unsigned m_r;
	longint unsigned m_a;
	logic [63:0] m_ctl [2];
	bit m_boost [2];
	bit m_dis;
	bit m_loaded;

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			m_loaded = 1'b0;
			m_dis = 1'b0;
			for (int i = 0; i < 2; i++) begin
				m_ref[i] = 0;
				m_act[i] = 0;
				m_ctl[i] = `ZERO64;
				m_boost[i] = 1'b0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				// Either counter wrapping clears the pair; boost adds one sixteenth.
				if (lp[i].active) begin
					m_r = m_ref[i] + `RATIO_ONE;
					m_a = m_act[i] + lp[i].ratio + m_boost[i];
					if (m_r < m_ref[i] || m_a < m_act[i]) begin
						m_r = 0;
						m_a = 0;
					end
					m_ref[i] = m_r;
					m_act[i] = m_a;
				end
				m_boost[i] = !m_dis && !m_ctl[i][`DISENGAGE_BIT] && head && crit && lp[i].active;
				// A software write wins over the increment of the same edge.
				if (req.wr && req.lp == i[0]) begin
					if (req.addr == `ADDR_REF_COUNTER) begin
						m_ref[i] = req.wdata;
					end
					if (req.addr == `ADDR_ACT_COUNTER) begin
						m_act[i] = req.wdata;
					end
					if (req.addr == `ADDR_PERF_TARGET_CONTROL) begin
						m_ctl[i] = req.wdata;
					end
				end
			end
			// The first edge after reset takes the strap, later ones take firmware writes.
			if (!m_loaded) begin
				m_dis = hw;
			end else if (req.wr && req.addr == `ADDR_MISC_FEATURE_ENABLES) begin
				m_dis = req.wdata[`BOOST_DISABLE_BIT];
			end
			m_loaded = 1'b1;
		end
	end

	// ==========================================================================
	// Shared tasks
	// ==========================================================================
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// One register access; the request stands for exactly one edge.
	task automatic acc(input logic w, input logic [0:0] l, input logic [11:0] a,
		input logic [63:0] wd, output logic [63:0] rd);
		@(posedge i_clk_sys);
		req <= '{rd: !w, wr: w, lp: l, addr: a, wdata: wd};
		@(posedge i_clk_sys);
		req <= '0;
		@(negedge i_clk_sys);
		if (!w) chk("rvalid", {63'h0, rvalid}, `ONE64);
		rd = rdata;
	endtask

	// Two idle edges after release, since the first one loads the strap.
	task automatic rst_dut(input logic s);
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		hw <= s;
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
	endtask

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		rnd = $urandom(32'h525f);
		i_rst = 1'b1;
		hw = 1'b1;
		head = 1'b1;
		crit = 1'b1;
		leaf = `CAP_LEAF_THERMAL;
		req = '0;
		lp = '0;
		op = 16'($urandom);
		bit32 = `ONE64 << `DISENGAGE_BIT;
		bit38 = `ONE64 << `BOOST_DISABLE_BIT;
		rst_dut(1'b1);
		acc(1'b0, 1'b0, `ADDR_MISC_FEATURE_ENABLES, `ZERO64, q);
		chk("strap", q & bit38, bit38);
		acc(1'b0, 1'b1, `ADDR_MISC_FEATURE_ENABLES, `ZERO64, q);
		chk("strap_lp1", q & bit38, bit38);
		chk("cap_off", {63'h0, eax[`CAP_BOOST_BIT]}, `ZERO64);
		chk("perm_off", {62'h0, perm}, `ZERO64);
		$display("Test strap done");
		d = {$urandom, $urandom} & ~bit38;
		acc(1'b1, 1'b1, `ADDR_MISC_FEATURE_ENABLES, d, q);
		acc(1'b0, 1'b0, `ADDR_MISC_FEATURE_ENABLES, `ZERO64, q);
		chk("misc", q, d);
		chk("cap_on", {63'h0, eax[`CAP_BOOST_BIT]}, `ONE64);
		@(posedge i_clk_sys);
		leaf <= 32'h0000_0007;
		@(negedge i_clk_sys);
		chk("cap_leaf", {32'h0, eax}, `ZERO64);
		chk("perm_on", {62'h0, perm}, 64'h3);
		@(posedge i_clk_sys);
		leaf <= `CAP_LEAF_THERMAL;
		$display("Test enable done");
		// Disengage one processor by read-modify-write of its control word.
		acc(1'b0, 1'b0, `ADDR_PERF_TARGET_CONTROL, `ZERO64, q);
		d = q | bit32 | 64'h0000_0000_0000_1234;
		acc(1'b1, 1'b0, `ADDR_PERF_TARGET_CONTROL, d, q);
		acc(1'b0, 1'b0, `ADDR_PERF_TARGET_CONTROL, `ZERO64, q);
		chk("ctl0", q, d);
		acc(1'b0, 1'b1, `ADDR_PERF_TARGET_CONTROL, `ZERO64, q);
		chk("ctl1", q, `ZERO64);
		chk("perm_dis", {62'h0, perm}, 64'h2);
		acc(1'b0, 1'b0, `ADDR_PERF_STATE_READBACK, `ZERO64, q);
		chk("readback", {47'h0, q[32], q[15:0]}, {48'h0, op});
		acc(1'b0, 1'b0, 12'h123, `ZERO64, q);
		chk("unmapped", q, `ZERO64);
		$display("Test disengage done");
		// Zero both counter pairs, reference first, then count for N edges.
		for (int i = 0; i < 2; i++) begin
			acc(1'b1, i[0], `ADDR_REF_COUNTER, `ZERO64, q);
			acc(1'b1, i[0], `ADDR_ACT_COUNTER, `ZERO64, q);
		end
		r0 = 8'($urandom);
		@(posedge i_clk_sys);
		lp <= '{'{active: 1'b1, ratio: `RATIO_ONE}, '{active: 1'b1, ratio: r0}};
		@(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk("boosted", {62'h0, boosted}, 64'h2);
		chk("boosted_model", {62'h0, boosted}, {62'h0, m_boost[1], m_boost[0]});
		repeat (N - 1) @(posedge i_clk_sys);
		lp <= '0;
		for (int i = 0; i < 2; i++) begin
			acc(1'b0, i[0], `ADDR_REF_COUNTER, `ZERO64, q);
			chk("ref", q, 64'(N * 16));
			chk("ref_model", q, m_ref[i]);
			acc(1'b0, i[0], `ADDR_ACT_COUNTER, `ZERO64, q);
			chk("act", q, (i == 0) ? 64'(N * r0) : 64'(N * 16 + N - 1));
			chk("act_model", q, m_act[i]);
		end
		$display("Test counters done");
		// Permission alone is not enough: headroom and the criteria gate boost too.
		@(posedge i_clk_sys);
		lp[1] <= '{active: 1'b1, ratio: `RATIO_ONE};
		for (int k = 0; k < 3; k++) begin
			head <= k != 0;
			crit <= k != 1;
			repeat (2) @(posedge i_clk_sys);
			@(negedge i_clk_sys);
			chk("gate", {62'h0, boosted}, (k == 2) ? 64'h2 : `ZERO64);
			chk("gate_model", {63'h0, boosted[1]}, {63'h0, m_boost[1]});
			@(posedge i_clk_sys);
		end
		lp <= '0;
		$display("Test gate done");
		// Overflow of the actual, then of the reference counter clears both; both resume.
		for (int k = 0; k < 2; k++) begin
			acc(1'b1, 1'b0, `ADDR_REF_COUNTER, k ? `ALL_ONES64 : `ZERO64, q);
			acc(1'b1, 1'b0, `ADDR_ACT_COUNTER, k ? `ZERO64 : `ALL_ONES64 - 64'h5, q);
			@(posedge i_clk_sys);
			lp[0] <= '{active: 1'b1, ratio: `RATIO_ONE};
			repeat (2) @(posedge i_clk_sys);
			lp <= '0;
			acc(1'b0, 1'b0, `ADDR_REF_COUNTER, `ZERO64, q);
			chk("wrap_ref", q, 64'h10);
			acc(1'b0, 1'b0, `ADDR_ACT_COUNTER, `ZERO64, q);
			chk("wrap_act", q, 64'h10);
			chk("wrap_model", q, m_act[0]);
		end
		$display("Test overflow done");
		rst_dut(1'b0);
		acc(1'b0, 1'b0, `ADDR_MISC_FEATURE_ENABLES, `ZERO64, q);
		chk("strap_off", q & bit38, `ZERO64);
		chk("strap_model", q & bit38, m_dis ? bit38 : `ZERO64);
		chk("cap_absent", {63'h0, eax[`CAP_BOOST_BIT]}, `ONE64);
		acc(1'b0, 1'b0, `ADDR_PERF_TARGET_CONTROL, `ZERO64, q);
		chk("ctl_rst", q, `ZERO64);
		$display("Test absent strap done");
		end_sim;
	end

	// The run needs about 130 cycles; the 3000-cycle limit, over twenty times that, means a hang.
	initial begin
		#(3000 * 100);
		miscompares++;
		end_sim;
	end
endmodule
